// ==== rtl/bdm_core.sv ====
// Banked data memory map: core registers, peripheral region decode, general and common RAM.
// Assumes requests come from CPU logic on clk_sys and peripherals answer reads combinationally.
`timescale 1ns/1ps

module bdm_core
(
	input  wire logic                   clk_sys,
	input  wire logic                   arst_n,
	input  wire bdm_pkg::bdm_req_type   req,
	output logic                        req_ready,
	output bdm_pkg::bdm_rsp_type        rsp,
	output bdm_pkg::bdm_periph_type     periph,
	input  wire logic [7:0]             periph_rdata,
	output bdm_pkg::bdm_core_type       core_regs
);

	////////////////////////////////////////////////////////////////////////////////
	// Address decoding.

	// Writes only the bits inside the mask; the others keep their value, so
	// unimplemented bits stay zero and read-only status bits survive a write.
	function automatic logic [7:0] merge_bits
	(
		input logic [7:0] old_val,
		input logic [7:0] new_val,
		input logic [7:0] mask
	);
		return (old_val & ~mask) | (new_val & mask);
	endfunction

	// Splits a twelve-bit banked address into its region and a register or RAM index.
	function automatic bdm_pkg::bdm_decode_type decode_banked(input logic [11:0] addr);
		bdm_pkg::bdm_decode_type d;
		logic [6:0]              off;
		logic [4:0]              bank;
		d    = '{region: bdm_pkg::RG_NONE, idx: '0};
		off  = addr[6:0];
		bank = addr[11:7];
		if (off < bdm_pkg::OFF_PERIPH_FIRST)
		begin
			d.region = bdm_pkg::RG_CORE;
			d.idx    = {5'h00, off};
		end
		else if (off <= bdm_pkg::OFF_PERIPH_LAST)
		begin
			if (bank >= bdm_pkg::BANK_REMAP_FIRST && bank <= bdm_pkg::BANK_REMAP_LAST)
				d.region = bdm_pkg::RG_REMAP;
			else
				d.region = bdm_pkg::RG_PERIPH;
			d.idx = addr;
		end
		else if (off < bdm_pkg::OFF_COMMON_FIRST)
		begin
			d.region = bdm_pkg::RG_GPR;
			d.idx    = 12'({7'h00, bank} * 12'(bdm_pkg::GPR_PER_BANK))
				+ {5'h00, off - bdm_pkg::OFF_GPR_FIRST};
		end
		else
		begin
			d.region = bdm_pkg::RG_COMMON;
			d.idx    = {5'h00, off - bdm_pkg::OFF_COMMON_FIRST};
		end
		return d;
	endfunction

	// Pointer space: a linear window onto all general RAM, banked addresses below it,
	// and nothing behind program memory or the unused range.
	function automatic bdm_pkg::bdm_decode_type decode_pointer(input logic [15:0] ptr);
		bdm_pkg::bdm_decode_type d;
		logic [15:0]             lin;
		d   = '{region: bdm_pkg::RG_NONE, idx: '0};
		lin = ptr - bdm_pkg::LINEAR_BASE;
		if (ptr[bdm_pkg::PTR_PROG_BIT])
			d.region = bdm_pkg::RG_NONE;
		else if (ptr >= bdm_pkg::LINEAR_BASE && ptr < bdm_pkg::LINEAR_LIMIT)
		begin
			d.region = bdm_pkg::RG_GPR;
			d.idx    = lin[11:0];
		end
		else if (ptr[15:12] == 4'h0)
		begin
			d = decode_banked(ptr[11:0]);
			// An indirect port addressed through a pointer has nothing behind it.
			if (d.region == bdm_pkg::RG_CORE && d.idx[6:0] <= bdm_pkg::OFF_IND1)
				d.region = bdm_pkg::RG_NONE;
		end
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State.

	// Idle takes requests; the peripheral state waits for the registered reply.
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b01,
		ST_PERIPH = 2'b10
	} bdm_state_type;

	bdm_state_type           state_r,     state_nxt;
	logic                    ready_r,     ready_nxt;
	bdm_pkg::bdm_rsp_type    rsp_r,       rsp_nxt;
	bdm_pkg::bdm_periph_type periph_r,    periph_nxt;
	bdm_pkg::bdm_core_type   core_r,      core_nxt;
	logic [7:0]              ptr0_lo_r,   ptr0_lo_nxt;
	logic [7:0]              ptr0_hi_r,   ptr0_hi_nxt;
	logic [7:0]              ptr1_lo_r,   ptr1_lo_nxt;
	logic [7:0]              ptr1_hi_r,   ptr1_hi_nxt;

	logic [7:0]              gpr_mem    [bdm_pkg::GPR_TOTAL];
	logic [7:0]              common_mem [bdm_pkg::COMMON_BYTES];
	logic                    gpr_we;
	logic                    common_we;
	logic [11:0]             mem_idx;

	bdm_pkg::bdm_decode_type dec;
	logic [11:0]             direct_addr;
	logic                    is_indirect;
	logic [7:0]              core_rd;
	logic                    take;

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	always_comb
	begin
		state_nxt   = state_r;
		ready_nxt   = ready_r;
		rsp_nxt     = '{ack: 1'b0, rdata: 8'h00};
		periph_nxt  = '{sel: 1'b0, remap_sel: 1'b0, write: 1'b0, addr: '0, wdata: 8'h00};
		core_nxt    = core_r;
		ptr0_lo_nxt = ptr0_lo_r;
		ptr0_hi_nxt = ptr0_hi_r;
		ptr1_lo_nxt = ptr1_lo_r;
		ptr1_hi_nxt = ptr1_hi_r;
		gpr_we      = 1'b0;
		common_we   = 1'b0;
		take        = req.valid && ready_r && state_r == ST_IDLE;

		// Direct accesses take the bank from bank select; the indirect ports use a pointer.
		direct_addr = {core_r.bsel[4:0], req.offset};
		is_indirect = req.offset == bdm_pkg::OFF_IND0 || req.offset == bdm_pkg::OFF_IND1;
		if (is_indirect)
			dec = decode_pointer(req.offset == bdm_pkg::OFF_IND0 ?
				{ptr0_hi_r, ptr0_lo_r} : {ptr1_hi_r, ptr1_lo_r});
		else
			dec = decode_banked(direct_addr);
		mem_idx = dec.idx;

		// Core register read data; offsets without a register read as zero.

		unique case (dec.idx[6:0])
			bdm_pkg::OFF_PCL:     core_rd = core_r.program_counter_low;
			bdm_pkg::OFF_STATUS:  core_rd = core_r.status;
			bdm_pkg::OFF_PTR0_LO: core_rd = ptr0_lo_r;
			bdm_pkg::OFF_PTR0_HI: core_rd = ptr0_hi_r;
			bdm_pkg::OFF_PTR1_LO: core_rd = ptr1_lo_r;
			bdm_pkg::OFF_PTR1_HI: core_rd = ptr1_hi_r;
			bdm_pkg::OFF_BSEL:    core_rd = core_r.bsel;
			bdm_pkg::OFF_WACC:    core_rd = core_r.wacc;
			bdm_pkg::OFF_PCLATCH: core_rd = core_r.pclatch;
			bdm_pkg::OFF_INTCTL:  core_rd = core_r.intctl;
			default:              core_rd = 8'h00;
		endcase

		unique case (state_r)
			ST_IDLE:
			begin
				if (take)
				begin
					unique case (dec.region)
						bdm_pkg::RG_CORE:
						begin
							rsp_nxt = '{ack: 1'b1, rdata: core_rd};
							if (req.write)
							begin
								unique case (dec.idx[6:0])
									bdm_pkg::OFF_PCL:     core_nxt.program_counter_low = req.wdata;
									bdm_pkg::OFF_STATUS:  core_nxt.status = merge_bits(
										core_r.status, req.wdata, bdm_pkg::MASK_STATUS_W);
									bdm_pkg::OFF_PTR0_LO: ptr0_lo_nxt = req.wdata;
									bdm_pkg::OFF_PTR0_HI: ptr0_hi_nxt = req.wdata;
									bdm_pkg::OFF_PTR1_LO: ptr1_lo_nxt = req.wdata;
									bdm_pkg::OFF_PTR1_HI: ptr1_hi_nxt = req.wdata;
									bdm_pkg::OFF_BSEL:    core_nxt.bsel =
										merge_bits(core_r.bsel, req.wdata, bdm_pkg::MASK_BSEL);
									bdm_pkg::OFF_WACC:    core_nxt.wacc = req.wdata;
									bdm_pkg::OFF_PCLATCH: core_nxt.pclatch =
										merge_bits(core_r.pclatch, req.wdata, bdm_pkg::MASK_PCLATCH);
									bdm_pkg::OFF_INTCTL:  core_nxt.intctl =
										merge_bits(core_r.intctl, req.wdata, bdm_pkg::MASK_INTCTL);
									default:              core_nxt = core_r;
								endcase
							end
						end
						// A peripheral answers one cycle later, so the port refuses requests meanwhile.
						bdm_pkg::RG_PERIPH, bdm_pkg::RG_REMAP:
						begin
							periph_nxt.sel       = dec.region == bdm_pkg::RG_PERIPH;
							periph_nxt.remap_sel = dec.region == bdm_pkg::RG_REMAP;
							periph_nxt.write     = req.write;
							periph_nxt.addr      = dec.idx;
							periph_nxt.wdata     = req.wdata;
							ready_nxt            = 1'b0;
							state_nxt            = ST_PERIPH;
						end
						// RAM writes return the old contents on the read data.
						bdm_pkg::RG_GPR:
						begin
							rsp_nxt = '{ack: 1'b1, rdata: gpr_mem[mem_idx]};
							gpr_we  = req.write;
						end
						bdm_pkg::RG_COMMON:
						begin
							rsp_nxt   = '{ack: 1'b1, rdata: common_mem[mem_idx[3:0]]};
							common_we = req.write;
						end
						bdm_pkg::RG_NONE:
							rsp_nxt = '{ack: 1'b1, rdata: 8'h00};
						default:
							rsp_nxt = '{ack: 1'b1, rdata: 8'h00};
					endcase
				end
			end
			// The peripheral reply stands while its select does and is captured here.
			ST_PERIPH:
			begin
				rsp_nxt   = '{ack: 1'b1, rdata: periph_r.write ? 8'h00 : periph_rdata};
				ready_nxt = 1'b1;
				state_nxt = ST_IDLE;
			end
			default:
			begin
				ready_nxt = 1'b1;
				state_nxt = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r   <= ST_IDLE;
			ready_r   <= 1'b1;
			rsp_r     <= '{ack: 1'b0, rdata: 8'h00};
			periph_r  <= '{sel: 1'b0, remap_sel: 1'b0, write: 1'b0, addr: '0, wdata: 8'h00};
			core_r    <= '{program_counter_low:     bdm_pkg::RST_PCL,
			               status:  bdm_pkg::RST_STATUS,
			               bsel:    bdm_pkg::RST_BSEL,
			               wacc:    bdm_pkg::RST_WACC,
			               pclatch: bdm_pkg::RST_PCLATCH,
			               intctl:  bdm_pkg::RST_INTCTL};
			ptr0_lo_r <= bdm_pkg::RST_PTR;
			ptr0_hi_r <= bdm_pkg::RST_PTR;
			ptr1_lo_r <= bdm_pkg::RST_PTR;
			ptr1_hi_r <= bdm_pkg::RST_PTR;
		end
		else
		begin
			state_r   <= state_nxt;
			ready_r   <= ready_nxt;
			rsp_r     <= rsp_nxt;
			periph_r  <= periph_nxt;
			core_r    <= core_nxt;
			ptr0_lo_r <= ptr0_lo_nxt;
			ptr0_hi_r <= ptr0_hi_nxt;
			ptr1_lo_r <= ptr1_lo_nxt;
			ptr1_hi_r <= ptr1_hi_nxt;
		end
	end

	// RAM contents are not reset, as in the device.
	always_ff @(posedge clk_sys)
	begin
		if (gpr_we)
			gpr_mem[mem_idx] <= req.wdata;
		if (common_we)
			common_mem[mem_idx[3:0]] <= req.wdata;
	end

	// Every output is the registered copy of its state.
	assign req_ready = ready_r;
	assign rsp       = rsp_r;
	assign periph    = periph_r;
	assign core_regs = core_r;

endmodule

// ==== rtl/bdm_pkg.sv ====
// Constants and carrier types for the banked data memory map.
// Assumes one system clock and a CPU core on the same clock as the only requester.
package bdm_pkg;

	localparam int unsigned ADDR_W       = 12;
	localparam int unsigned OFF_W        = 7;
	localparam int unsigned BANK_W       = 5;
	localparam int unsigned PTR_W        = 16;
	localparam int unsigned IDX_W        = 12;
	localparam int unsigned GPR_PER_BANK = 80;
	localparam int unsigned BANK_COUNT   = 32;
	localparam int unsigned GPR_TOTAL    = GPR_PER_BANK * BANK_COUNT;
	localparam int unsigned COMMON_BYTES = 16;

	// Bank offsets of the core registers.
	localparam logic [6:0] OFF_IND0     = 7'h00;
	localparam logic [6:0] OFF_IND1     = 7'h01;
	localparam logic [6:0] OFF_PCL      = 7'h02;
	localparam logic [6:0] OFF_STATUS   = 7'h03;
	localparam logic [6:0] OFF_PTR0_LO  = 7'h04;
	localparam logic [6:0] OFF_PTR0_HI  = 7'h05;
	localparam logic [6:0] OFF_PTR1_LO  = 7'h06;
	localparam logic [6:0] OFF_PTR1_HI  = 7'h07;
	localparam logic [6:0] OFF_BSEL     = 7'h08;
	localparam logic [6:0] OFF_WACC     = 7'h09;
	localparam logic [6:0] OFF_PCLATCH  = 7'h0a;
	localparam logic [6:0] OFF_INTCTL   = 7'h0b;

	// Region boundaries inside one bank.
	localparam logic [6:0] OFF_PERIPH_FIRST = 7'h0c;
	localparam logic [6:0] OFF_PERIPH_LAST  = 7'h1f;
	localparam logic [6:0] OFF_GPR_FIRST    = 7'h20;
	localparam logic [6:0] OFF_COMMON_FIRST = 7'h70;

	// Banks whose peripheral region holds pin remap and configurable logic registers.
	localparam logic [4:0] BANK_REMAP_FIRST = 5'h1b;
	localparam logic [4:0] BANK_REMAP_LAST  = 5'h1d;

	// Linear window onto the general RAM of all banks.
	localparam logic [15:0] LINEAR_BASE  = 16'h2000;
	localparam logic [15:0] LINEAR_LIMIT = 16'h2a00;
	localparam int unsigned PTR_PROG_BIT = 15;

	// Reset values and writable bit masks.
	localparam logic [7:0] RST_PCL      = 8'h00;
	localparam logic [7:0] RST_STATUS   = 8'h18;
	localparam logic [7:0] RST_PTR      = 8'h00;
	localparam logic [7:0] RST_BSEL     = 8'h00;
	localparam logic [7:0] RST_WACC     = 8'h00;
	localparam logic [7:0] RST_PCLATCH  = 8'h00;
	localparam logic [7:0] RST_INTCTL   = 8'h01;
	localparam logic [7:0] MASK_STATUS_W = 8'h07;
	localparam logic [7:0] MASK_BSEL     = 8'h1f;
	localparam logic [7:0] MASK_PCLATCH  = 8'h7f;
	localparam logic [7:0] MASK_INTCTL   = 8'hc1;

	typedef enum logic [5:0] {
		RG_CORE   = 6'b000001,
		RG_PERIPH = 6'b000010,
		RG_REMAP  = 6'b000100,
		RG_GPR    = 6'b001000,
		RG_COMMON = 6'b010000,
		RG_NONE   = 6'b100000
	} bdm_region_type;

	typedef struct packed {
		bdm_region_type         region;
		logic [IDX_W-1:0]       idx;
	} bdm_decode_type;

	typedef struct packed {
		logic                   valid;
		logic                   write;
		logic [OFF_W-1:0]       offset;
		logic [7:0]             wdata;
	} bdm_req_type;

	typedef struct packed {
		logic                   ack;
		logic [7:0]             rdata;
	} bdm_rsp_type;

	typedef struct packed {
		logic                   sel;
		logic                   remap_sel;
		logic                   write;
		logic [ADDR_W-1:0]      addr;
		logic [7:0]             wdata;
	} bdm_periph_type;

	typedef struct packed {
		logic [7:0]             program_counter_low;
		logic [7:0]             status;
		logic [7:0]             bsel;
		logic [7:0]             wacc;
		logic [7:0]             pclatch;
		logic [7:0]             intctl;
	} bdm_core_type;

endpackage

// ==== verification/banked_data_memory_map_test.sv ====
// Self-checking bench for the banked data memory map.
// Uses bdm_periph_model as the peripheral side.
`timescale 1ns/1ps
module banked_data_memory_map_test;
	logic                    clk_sys = 1'b0;
	logic                    arst_n = 1'b0;
	bdm_pkg::bdm_req_type    req = '0;
	logic                    req_ready;
	bdm_pkg::bdm_rsp_type    rsp;
	bdm_pkg::bdm_periph_type periph;
	logic [7:0]              periph_rdata;
	bdm_pkg::bdm_core_type   core_regs;
	int                      n_mismatch = 0;
	int                      compares = 0;
	logic [7:0]              rd;
	bdm_pkg::bdm_periph_type pv;
	logic                    rdy_seen;
	always #10 clk_sys = ~clk_sys;
	bdm_core u_dut (.clk_sys, .arst_n, .req, .req_ready, .rsp, .periph, .periph_rdata, .core_regs);
	bdm_periph_model u_periph (.clk_sys, .periph, .periph_rdata);
	////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One access: request held until an edge with req_ready high, then the ack awaited.
	task automatic acc(input logic w, input logic [6:0] o, input logic [7:0] d);
		int n;
		@(posedge clk_sys);
		#1;
		req = '{valid: 1'b1, write: w, offset: o, wdata: d};
		for (n = 0; n < 4 && req_ready !== 1'b1; n++)
		begin
			@(posedge clk_sys);
			#1;
		end
		@(posedge clk_sys);
		#1;
		req = '0;
		pv = periph;
		rdy_seen = req_ready;
		for (n = 0; n < 4 && rsp.ack !== 1'b1; n++)
		begin
			@(posedge clk_sys);
			#1;
		end
		if (rsp.ack !== 1'b1)
		begin
			n_mismatch++;
			$display("[FAIL] ack expected 1 seen %b", rsp.ack);
			print_verdict();
		end
		rd = rsp.rdata;
	endtask
	task automatic wr(input logic [6:0] o, input logic [7:0] d);
		acc(1'b1, o, d);
	endtask
	task automatic rdchk(input string what, input logic [6:0] o, input logic [7:0] e);
		acc(1'b0, o, 8'h00);
		check(what, rd, e);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		check("core regs", core_regs, 48'h00_18_00_00_00_01);
		rdchk("pcl", 7'h02, 8'h00);
		rdchk("status", 7'h03, 8'h18);
		$display("test reset done");
	endtask
	task automatic t_mask;
		logic [6:0] offs [4] = '{7'h03, 7'h08, 7'h0a, 7'h0b};
		logic [7:0] exps [4] = '{8'h1f, 8'h1f, 8'h7f, 8'hc1};
		foreach (offs[i])
		begin
			wr(offs[i], 8'hff);
			rdchk("masked", offs[i], exps[i]);
		end
		wr(7'h03, 8'h00);
		rdchk("status ro", 7'h03, 8'h18);
		wr(7'h02, 8'h42);
		check("pcl", core_regs.program_counter_low, 8'h42);
		$display("test mask done");
	endtask
	task automatic t_periph;
		logic [4:0] banks [6] = '{5'h00, 5'h1a, 5'h1b, 5'h1c, 5'h1d, 5'h1f};
		logic [11:0] a;
		logic [7:0]  e;
		logic        rmp;
		foreach (banks[i])
		begin
			wr(7'h08, {3'h0, banks[i]});
			rmp = banks[i] >= 5'h1b && banks[i] <= 5'h1d;
			a = {banks[i], 7'h0c};
			e = a[7:0] ^ {a[11:8], 4'h0};
			rdchk("periph first", 7'h0c, rmp ? ~e : e);
			check("select", {pv.sel, pv.remap_sel}, rmp ? 2'b01 : 2'b10);
			a = {banks[i], 7'h1f};
			e = a[7:0] ^ {a[11:8], 4'h0};
			rdchk("periph last", 7'h1f, rmp ? ~e : e);
		end
		acc(1'b1, 7'h10, 8'h77);
		check("periph write", rd, 8'h00);
		check("periph bus", pv, {1'b1, 1'b0, 1'b1, 12'hf90, 8'h77});
		check("busy", rdy_seen, 1'b0);
		$display("test periph done");
	endtask
	task automatic t_ram;
		wr(7'h08, 8'h00);
		wr(7'h20, 8'haa);
		wr(7'h08, 8'h01);
		wr(7'h20, 8'hbb);
		wr(7'h70, 8'h3c);
		wr(7'h08, 8'h05);
		rdchk("common", 7'h70, 8'h3c);
		wr(7'h08, 8'h00);
		rdchk("bank ram", 7'h20, 8'haa);
		wr(7'h04, 8'h50);
		wr(7'h05, 8'h20);
		rdchk("linear", 7'h00, 8'hbb);
		wr(7'h06, 8'h70);
		wr(7'h07, 8'h00);
		rdchk("indirect", 7'h01, 8'h3c);
		wr(7'h00, 8'h5a);
		wr(7'h08, 8'h01);
		rdchk("ind write", 7'h20, 8'h5a);
		wr(7'h04, 8'h8c);
		wr(7'h05, 8'h0f);
		rdchk("ind periph", 7'h00, 8'h7c);
		wr(7'h05, 8'h80);
		rdchk("prog space", 7'h00, 8'h00);
		wr(7'h06, 8'h09);
		wr(7'h01, 8'h66);
		check("ind core", core_regs.wacc, 8'h66);
		$display("test ram done");
	endtask
	task automatic t_rerun;
		@(posedge clk_sys);
		#1;
		arst_n = 1'b0;
		@(posedge clk_sys);
		#1;
		check("reset regs", core_regs, 48'h00_18_00_00_00_01);
		arst_n = 1'b1;
		rdchk("pcl after reset", 7'h02, 8'h00);
		$display("test rerun done");
	endtask
	initial
	begin
		repeat (20) @(posedge clk_sys);
		#1;
		arst_n = 1'b1;
		t_reset();
		t_mask();
		t_periph();
		t_ram();
		t_rerun();
		print_verdict();
	end
endmodule

// ==== verification/bdm_core_sva.sv ====
// Checker for the banked data memory map ports.
// Bound to bdm_core; sees only its ports.
`timescale 1ns/1ps
module bdm_core_sva
(
	input wire logic                    clk_sys,
	input wire logic                    arst_n,
	input wire bdm_pkg::bdm_req_type    req,
	input wire logic                    req_ready,
	input wire bdm_pkg::bdm_rsp_type    rsp,
	input wire bdm_pkg::bdm_periph_type periph,
	input wire logic [7:0]              periph_rdata,
	input wire bdm_pkg::bdm_core_type   core_regs
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	logic take;
	logic preg;
	logic rbank;
	logic psel;
	assign take = req.valid && req_ready;
	assign preg = req.offset >= 7'h0c && req.offset <= 7'h1f;
	assign rbank = core_regs.bsel[4:0] >= 5'h1b && core_regs.bsel[4:0] <= 5'h1d;
	assign psel = periph.sel || periph.remap_sel;
	property p_sel; take && preg && !rbank |=> periph.sel && !periph.remap_sel; endproperty
	a_sel: assert property (p_sel) else $error("peripheral select missing");
	property p_remap; take && preg && rbank |=> periph.remap_sel && !periph.sel; endproperty
	a_remap: assert property (p_remap) else $error("remap select missing");
	property p_addr;
		take && preg |=> periph.addr == {$past(core_regs.bsel[4:0]), $past(req.offset)};
	endproperty
	a_addr: assert property (p_addr) else $error("peripheral address wrong");
	property p_rd; psel && !periph.write |=> rsp.ack && rsp.rdata == $past(periph_rdata); endproperty
	a_rd: assert property (p_rd) else $error("peripheral read data wrong");
	property p_busy; psel |-> !req_ready ##1 req_ready; endproperty
	a_busy: assert property (p_busy) else $error("ready timing wrong");
	property p_pcl; take && req.write && req.offset == 7'h02 |=> core_regs.program_counter_low == $past(req.wdata);
	endproperty
	a_pcl: assert property (p_pcl) else $error("pcl not written");
	property p_fix;
		core_regs.status[7:3] == 5'h03 && core_regs.bsel[7:5] == 3'h0
			&& core_regs.pclatch[7] == 1'b0 && (core_regs.intctl & 8'h3e) == 8'h00;
	endproperty
	a_fix: assert property (p_fix) else $error("unimplemented bit set");
	property p_ack; take && !preg && req.offset > 7'h01 |=> rsp.ack && !psel; endproperty
	a_ack: assert property (p_ack) else $error("core or ram ack missing");
	c_sel: cover property (periph.sel);
	c_remap: cover property (periph.remap_sel);
	c_ind: cover property (take && req.offset == 7'h00);
	c_ind_periph: cover property (take && req.offset <= 7'h01 ##1 psel);
endmodule
bind bdm_core bdm_core_sva u_sva (.clk_sys, .arst_n, .req, .req_ready, .rsp, .periph,
	.periph_rdata, .core_regs);

// ==== verification/bdm_periph_model.sv ====
// Peripheral register stand-in on the far side of the peripheral region.
// Answers reads combinationally; drives a moving pattern when not selected.
`timescale 1ns/1ps
module bdm_periph_model
(
	input wire logic                    clk_sys,
	input wire bdm_pkg::bdm_periph_type periph,
	output logic [7:0]                  periph_rdata
);
	logic [7:0] cnt_r = 8'h00;
	always @(posedge clk_sys)
	begin
		cnt_r <= cnt_r + 8'h01;
	end
	logic [7:0] pattern;
	assign pattern = periph.addr[7:0] ^ {periph.addr[11:8], 4'h0};
	// Remap registers answer with the inverted pattern so the two selects can be told apart.
	assign periph_rdata = periph.remap_sel ? ~pattern : periph.sel ? pattern : cnt_r;
endmodule
